// *** rtl/rss_sequencer.sv ***
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rss_sequencer (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic turn_on_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [rss_pkg::NUM_RAILS-1:0] rail_en_out,
  output logic [5:0] rail_vsel_out [rss_pkg::NUM_RAILS],
  output logic boost_en_out,
  output logic otg_sw_en_out,
  output logic pwr_sw_en_out,
  output logic [7:0] prot_cfg_out,
  output logic [7:0] pdown_cfg_out,
  output logic [6:0] slave_addr_out,
  output logic seq_done_out
);
  import rss_pkg::*;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [NUM_RAILS-1:0] rank_mask(
    input logic [DATA_W-1:0] words [CFG_WORDS],
    input logic [1:0] rank
  );
    logic [NUM_RAILS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_RAILS; i++) begin
      m[i] = (words[i][RANK_W-1:0] == rank);
    end
    return m;
  endfunction : rank_mask

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : reg_hit

  // ------------------------------------------------------------
  // Input synchroniser and config store
  // ------------------------------------------------------------
  logic turn_on_sync;
  logic turn_on_d_ff;
  logic locked;
  logic [DATA_W-1:0] cfg_words [CFG_WORDS];

  rss_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .async_in(turn_on_in),
    .sync_out(turn_on_sync)
  );

  wire cfg_sel = (reg_addr_in[7:4] == REG_CFG_BASE[7:4]);
  wire cfg_wr = reg_wr_in && cfg_sel;
  wire lock_wr = reg_wr_in && reg_hit(reg_addr_in, REG_LOCK) && reg_wdata_in[0];

  rss_cfg_store u_cfg (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .wr_in(cfg_wr),
    .addr_in(reg_addr_in[CFG_AW-1:0]),
    .wdata_in(reg_wdata_in),
    .lock_set_in(lock_wr),
    .locked_out(locked),
    .word_out(cfg_words)
  );

  // ------------------------------------------------------------
  // Rank decode
  // ------------------------------------------------------------
  wire [NUM_RAILS-1:0] mask1 = rank_mask(cfg_words, RANK_ONE);
  wire [NUM_RAILS-1:0] mask2 = rank_mask(cfg_words, RANK_TWO);
  wire [NUM_RAILS-1:0] mask3 = rank_mask(cfg_words, RANK_THREE);
  wire auto_on = cfg_words[CFG_FLAGS][FLAG_AUTO_ON_BIT];
  wire turn_on_rise = turn_on_sync && !turn_on_d_ff;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  rss_state_t state_ff;
  rss_state_t nxt_state;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] nxt_tmr;
  logic [NUM_RAILS-1:0] auto_en_ff;
  logic [NUM_RAILS-1:0] nxt_auto_en;
  logic [NUM_RAILS-1:0] man_en_ff;
  logic [2:0] ctrl_ff;

  localparam logic [TMR_W-1:0] T1 = TMR_W'(RANK1_CYC - 1);
  localparam logic [TMR_W-1:0] TS = TMR_W'(RANK_STEP_CYC - 1);

  wire tmr_hit = (state_ff == RSS_WAIT1) ? (tmr_ff == T1) : (tmr_ff == TS);

  // Single timer restarted at each rank, so delays accumulate from turn-on
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff + 1'b1;
    nxt_auto_en = auto_en_ff;
    case (state_ff)
      RSS_IDLE: begin
        nxt_tmr = '0;
        if (turn_on_rise && auto_on) begin
          nxt_state = RSS_WAIT1;
        end
      end
      RSS_WAIT1: begin
        if (tmr_hit) begin
          nxt_auto_en = auto_en_ff | mask1;
          nxt_tmr = '0;
          nxt_state = RSS_WAIT2;
        end
      end
      RSS_WAIT2: begin
        if (tmr_hit) begin
          nxt_auto_en = auto_en_ff | mask2;
          nxt_tmr = '0;
          nxt_state = RSS_WAIT3;
        end
      end
      RSS_WAIT3: begin
        if (tmr_hit) begin
          nxt_auto_en = auto_en_ff | mask3;
          nxt_tmr = '0;
          nxt_state = RSS_DONE;
        end
      end
      RSS_DONE: begin
        nxt_tmr = '0;
      end
      default: begin
        nxt_state = RSS_IDLE;
        nxt_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state_ff <= RSS_IDLE;
      tmr_ff <= '0;
      auto_en_ff <= '0;
      turn_on_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      auto_en_ff <= nxt_auto_en;
      turn_on_d_ff <= turn_on_sync;
    end
  end

  // ------------------------------------------------------------
  // Explicit command registers
  // ------------------------------------------------------------
  wire ctrl_wr = reg_wr_in && reg_hit(reg_addr_in, REG_CTRL);
  wire man_lo_wr = reg_wr_in && reg_hit(reg_addr_in, REG_MAN_LO);
  wire man_hi_wr = reg_wr_in && reg_hit(reg_addr_in, REG_MAN_HI);

  // Boost and switches have no path from the sequencer
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl_ff <= 3'h0;
      man_en_ff <= '0;
    end else begin
      if (ctrl_wr) begin
        ctrl_ff <= reg_wdata_in[2:0];
      end
      if (man_lo_wr) begin
        man_en_ff[7:0] <= reg_wdata_in;
      end
      if (man_hi_wr) begin
        man_en_ff[9:8] <= reg_wdata_in[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  wire [NUM_RAILS-1:0] rail_all = auto_en_ff | man_en_ff;
  wire [7:0] status_val = {4'h0, locked, state_ff};

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (cfg_sel) begin
      rd_mux = cfg_words[reg_addr_in[CFG_AW-1:0]];
    end else begin
      case (reg_addr_in)
        REG_CTRL: rd_mux = {5'h00, ctrl_ff};
        REG_LOCK: rd_mux = {7'h00, locked};
        REG_STATUS: rd_mux = status_val;
        REG_RAIL_LO: rd_mux = rail_all[7:0];
        REG_RAIL_HI: rd_mux = {6'h00, rail_all[9:8]};
        REG_MAN_LO: rd_mux = man_en_ff[7:0];
        REG_MAN_HI: rd_mux = {6'h00, man_en_ff[9:8]};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
      rail_en_out <= '0;
      boost_en_out <= 1'b0;
      otg_sw_en_out <= 1'b0;
      pwr_sw_en_out <= 1'b0;
      prot_cfg_out <= 8'h00;
      pdown_cfg_out <= 8'h00;
      slave_addr_out <= 7'h00;
      seq_done_out <= 1'b0;
      for (int i = 0; i < NUM_RAILS; i++) begin
        rail_vsel_out[i] <= 6'h00;
      end
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
      rail_en_out <= rail_all;
      boost_en_out <= ctrl_ff[CTRL_BOOST_BIT];
      otg_sw_en_out <= ctrl_ff[CTRL_OTG_BIT];
      pwr_sw_en_out <= ctrl_ff[CTRL_PSW_BIT];
      prot_cfg_out <= cfg_words[CFG_PROT];
      pdown_cfg_out <= cfg_words[CFG_PDOWN];
      slave_addr_out <= cfg_words[CFG_SLAVE_ADDR][6:0];
      seq_done_out <= (state_ff == RSS_DONE);
      for (int i = 0; i < NUM_RAILS; i++) begin
        rail_vsel_out[i] <= cfg_words[i][7:2];
      end
    end
  end
endmodule : rss_sequencer

// *** rtl/rss_pkg.sv ***
package rss_pkg;
  // ------------------------------------------------------------
  // Rails and ranks
  // ------------------------------------------------------------
  localparam int unsigned NUM_RAILS = 10;  // 4 bucks, 6 LDOs
  localparam int unsigned RANK_W = 2;
  localparam logic [1:0] RANK_OFF = 2'h0;
  localparam logic [1:0] RANK_ONE = 2'h1;
  localparam logic [1:0] RANK_TWO = 2'h2;
  localparam logic [1:0] RANK_THREE = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned RANK1_DELAY_MS = 7;
  localparam int unsigned RANK_STEP_MS = 3;
  localparam int unsigned RANK1_CYC = CLK_HZ / 1000 * RANK1_DELAY_MS;
  localparam int unsigned RANK_STEP_CYC = CLK_HZ / 1000 * RANK_STEP_MS;
  localparam int unsigned TMR_W = 24;

  // ------------------------------------------------------------
  // Config store layout (word index, 8-bit words)
  // ------------------------------------------------------------
  localparam int unsigned CFG_WORDS = 16;
  localparam int unsigned CFG_AW = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] CFG_RANK_BASE = 4'h0;   // words 0..9: rank per rail
  localparam logic [3:0] CFG_VSEL_BASE = 4'h0;   // vsel in bits 7:2 of same words
  localparam logic [3:0] CFG_PROT = 4'hA;
  localparam logic [3:0] CFG_FLAGS = 4'hB;       // bit0 auto turn-on
  localparam logic [3:0] CFG_SLAVE_ADDR = 4'hC;
  localparam logic [3:0] CFG_PDOWN = 4'hD;
  localparam int unsigned FLAG_AUTO_ON_BIT = 0;
  localparam logic [7:0] CFG_RESET_VAL = 8'h00;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CFG_BASE = 8'h00;   // 0x00..0x0F config store
  localparam logic [7:0] REG_CTRL = 8'h10;       // bit0 boost, bit1 otg sw, bit2 pwr sw
  localparam logic [7:0] REG_LOCK = 8'h11;       // bit0 config_store_lock
  localparam logic [7:0] REG_STATUS = 8'h12;     // bits 2:0 state, bit3 locked
  localparam logic [7:0] REG_RAIL_LO = 8'h13;    // rail enables 7:0
  localparam logic [7:0] REG_RAIL_HI = 8'h14;    // rail enables 9:8
  localparam logic [7:0] REG_MAN_LO = 8'h15;     // manual rail enables 7:0
  localparam logic [7:0] REG_MAN_HI = 8'h16;
  localparam int unsigned CTRL_BOOST_BIT = 0;
  localparam int unsigned CTRL_OTG_BIT = 1;
  localparam int unsigned CTRL_PSW_BIT = 2;

  typedef enum logic [2:0] {
    RSS_IDLE,
    RSS_WAIT1,
    RSS_WAIT2,
    RSS_WAIT3,
    RSS_DONE
  } rss_state_t;
endpackage : rss_pkg

// *** rtl/rss_sync.sv ***
`timescale 1ns/1ps
module rss_sync (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : rss_sync

// *** rtl/rss_cfg_store.sv ***
`timescale 1ns/1ps
module rss_cfg_store (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic wr_in,
  input wire logic [rss_pkg::CFG_AW-1:0] addr_in,
  input wire logic [rss_pkg::DATA_W-1:0] wdata_in,
  input wire logic lock_set_in,
  output logic locked_out,
  output logic [rss_pkg::DATA_W-1:0] word_out [rss_pkg::CFG_WORDS]
);
  import rss_pkg::*;

  // Models the non-volatile array: contents survive srst, only power-on init
  logic [DATA_W-1:0] mem_ff [CFG_WORDS];
  logic lock_ff;

  // Power-on image; plain always below so this init is not a second driver
  initial begin
    lock_ff = 1'b0;
    for (int i = 0; i < CFG_WORDS; i++) begin
      mem_ff[i] = CFG_RESET_VAL;
    end
  end

  wire wr_ok = wr_in && !lock_ff;

  always @(posedge sys_clk_in) begin
    if (wr_ok) begin
      mem_ff[addr_in] <= wdata_in;
    end
  end

  // Lock is one-way; no reset clears it
  always @(posedge sys_clk_in) begin
    if (lock_set_in) begin
      lock_ff <= 1'b1;
    end
  end

  assign locked_out = lock_ff;
  assign word_out = mem_ff;
endmodule : rss_cfg_store

// *** sim/rss_sequencer_chk.sv ***
`timescale 1ns/1ps
module rss_sequencer_chk (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic turn_on_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [rss_pkg::NUM_RAILS-1:0] rail_en_out,
  input wire logic boost_en_out,
  input wire logic otg_sw_en_out,
  input wire logic pwr_sw_en_out,
  input wire logic seq_done_out
);
  import rss_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  logic [19:0] on_cnt_ff;
  logic on_run_ff;
  logic [2:0] man_hist_ff;
  logic [2:0] ctrl_hist_ff;
  wire man_wr = reg_wr_in && reg_addr_in inside {REG_MAN_LO, REG_MAN_HI};
  wire ctrl_wr = reg_wr_in && reg_addr_in == REG_CTRL;
  // Slack of 12 cycles absorbs the turn-on synchroniser and edge detect
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      on_run_ff <= 1'b0;
      on_cnt_ff <= 20'h0;
      man_hist_ff <= 3'h0;
      ctrl_hist_ff <= 3'h0;
    end else begin
      on_run_ff <= on_run_ff | turn_on_in;
      on_cnt_ff <= on_cnt_ff + 20'(on_run_ff && on_cnt_ff != 20'hFFFFF);
      man_hist_ff <= {man_hist_ff[1:0], man_wr};
      ctrl_hist_ff <= {ctrl_hist_ff[1:0], ctrl_wr};
    end
  end
  function automatic logic near(input logic [19:0] c, input int k0, input int k1);
    near = 1'b0;
    for (int k = k0; k <= k1; k++)
      near |= c >= RANK1_CYC + k * RANK_STEP_CYC && c <= RANK1_CYC + k * RANK_STEP_CYC + 12;
  endfunction : near
  sequence s_auto_step;
    rail_en_out != $past(rail_en_out) && man_hist_ff == 3'h0;
  endsequence
  sequence s_ctrl_set(b);
    ctrl_wr && reg_wdata_in[b];
  endsequence
  chk_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside a read answer");
  chk_rank_instant: assert property (s_auto_step |-> near(on_cnt_ff, 0, 2))
    else $error("rails changed off a rank instant");
  chk_rails_rise: assert property (s_auto_step |-> ($past(rail_en_out) & ~rail_en_out) == '0)
    else $error("rail dropped during power-up");
  chk_done_instant: assert property ($rose(seq_done_out) |-> near(on_cnt_ff, 2, 2))
    else $error("sequence end off the last instant");
  chk_done_holds: assert property (seq_done_out |=> seq_done_out)
    else $error("sequence end flag dropped");
  chk_boost_cmd: assert property (s_ctrl_set(CTRL_BOOST_BIT) |-> ##[1:3] boost_en_out)
    else $error("boost ignored its command");
  chk_boost_auto: assert property ($rose(boost_en_out) |-> ctrl_hist_ff != 3'h0)
    else $error("boost rose without command");
  chk_switch_auto: assert property ($rose(otg_sw_en_out | pwr_sw_en_out) |-> ctrl_hist_ff != 3'h0)
    else $error("switch rose without command");
endmodule : rss_sequencer_chk

bind rss_sequencer rss_sequencer_chk rss_sequencer_chk_i (.sys_clk_in, .srst_in, .turn_on_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rail_en_out,
  .boost_en_out, .otg_sw_en_out, .pwr_sw_en_out, .seq_done_out);

// *** sim/rss_host_model.sv ***
`timescale 1ns/1ps
module rss_host_model (
  input wire logic sys_clk_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out
);
  logic [7:0] exp_q [$];
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // Strobes stay up across back-to-back calls of one task; the other task or idle drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    reg_rd_out <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    reg_wr_out <= 1'b0;
    @(posedge sys_clk_in);
  endtask : rd
  // Released bus shows inverted values, not the last ones
  task automatic idle;
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~reg_addr_out;
    reg_wdata_out <= ~reg_wdata_out;
    @(posedge sys_clk_in);
  endtask : idle
endmodule : rss_host_model

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import rss_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic turn_on_in = 1'b0;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, prot_cfg_out, pdown_cfg_out;
  logic reg_wr_in, reg_rd_in, boost_en_out, otg_sw_en_out, pwr_sw_en_out, seq_done_out;
  logic [NUM_RAILS-1:0] rail_en_out, want;
  logic [5:0] rail_vsel_out [NUM_RAILS];
  logic [6:0] slave_addr_out;
  logic [7:0] cfg [14];
  logic rd_seen = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  integer seed = 32'ha9f520b3;
  always #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  rss_host_model rss_host_model_i (.sys_clk_in, .reg_addr_out(reg_addr_in),
    .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));
  rss_sequencer rss_sequencer_i (.sys_clk_in, .srst_in, .turn_on_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rail_en_out, .rail_vsel_out,
    .boost_en_out, .otg_sw_en_out, .pwr_sw_en_out, .prot_cfg_out, .pdown_cfg_out,
    .slave_addr_out, .seq_done_out);
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  function automatic logic [9:0] upto(input int r);
    upto = '0;
    for (int i = 0; i < 10; i++)
      upto[i] = cfg[i][1:0] != RANK_OFF && cfg[i][1:0] <= 2'(r);
  endfunction : upto
  // Exact match also proves rank-zero and later-rank rails are still off
  task automatic wait_rails(input int r);
    int n;
    n = 0;
    while (rail_en_out !== upto(r) && n < 400000) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n == 400000) begin
      n_fail++;
      finish_test();
    end
    n = cyc - t0 - RANK1_CYC - (r - 1) * RANK_STEP_CYC;
    check("rank instant", 16'(n >= 0 && n <= 12), 16'h0001);
  endtask : wait_rails
  always @(posedge sys_clk_in) begin
    if (rd_seen)
      check("read data", 16'(reg_rdata_out), 16'(rss_host_model_i.exp_q.pop_front()));
    rd_seen <= reg_rd_in;
  end
  initial begin
    repeat (10) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    rss_host_model_i.rd(REG_CTRL, 8'h00);
    rss_host_model_i.rd(REG_STATUS, 8'h00);
    rss_host_model_i.wr(8'h20, 8'hFF);
    rss_host_model_i.rd(8'h20, 8'h00);
    rss_host_model_i.idle();
    $display("end reset test");
    for (int i = 0; i < 14; i++) begin
      cfg[i] = 8'($random(seed));
      if (i < 4) cfg[i][1:0] = 2'(i);
      if (i == CFG_FLAGS) cfg[i][FLAG_AUTO_ON_BIT] = 1'b1;
      rss_host_model_i.wr(8'(i), cfg[i]);
    end
    for (int i = 0; i < 14; i++)
      rss_host_model_i.rd(8'(i), cfg[i]);
    rss_host_model_i.idle();
    repeat (2) @(posedge sys_clk_in);
    check("protection", 16'(prot_cfg_out), 16'(cfg[CFG_PROT]));
    check("slave address", 16'(slave_addr_out), 16'(cfg[CFG_SLAVE_ADDR][6:0]));
    check("power-down", 16'(pdown_cfg_out), 16'(cfg[CFG_PDOWN]));
    for (int i = 0; i < 10; i++)
      check("voltage", 16'(rail_vsel_out[i]), 16'(cfg[i][7:2]));
    $display("end config test");
    for (int b = 0; b < 3; b++) begin
      rss_host_model_i.wr(REG_CTRL, 8'(1 << b));
      rss_host_model_i.rd(REG_CTRL, 8'(1 << b));
      rss_host_model_i.idle();
      repeat (2) @(posedge sys_clk_in);
      check("switches", 16'({pwr_sw_en_out, otg_sw_en_out, boost_en_out}), 16'(1 << b));
    end
    rss_host_model_i.wr(REG_CTRL, 8'h00);
    rss_host_model_i.wr(REG_LOCK, 8'h01);
    rss_host_model_i.wr(8'h00, ~cfg[0]);
    rss_host_model_i.rd(8'h00, cfg[0]);
    rss_host_model_i.rd(REG_STATUS, 8'h08);
    rss_host_model_i.idle();
    $display("end lock test");
    turn_on_in <= 1'b1;
    t0 = cyc;
    for (int r = 1; r < 4; r++)
      wait_rails(r);
    repeat (4) @(posedge sys_clk_in);
    check("done", 16'(seq_done_out), 16'h0001);
    check("switches", 16'({pwr_sw_en_out, otg_sw_en_out, boost_en_out}), 16'h0000);
    want = upto(3) | 10'h001;
    rss_host_model_i.wr(REG_MAN_LO, 8'h01);
    rss_host_model_i.idle();
    repeat (3) @(posedge sys_clk_in);
    rss_host_model_i.rd(REG_RAIL_LO, want[7:0]);
    rss_host_model_i.rd(REG_RAIL_HI, {6'h00, want[9:8]});
    rss_host_model_i.idle();
    @(posedge sys_clk_in);
    $display("end sequence test");
    finish_test();
  end
endmodule : tb_top
